// *** core/camera_safe_power_sequencer.v ***
// Safe-power sequencer for cable-powered cameras, with an Avalon-MM slave.
// Assumes the sense front end, overcurrent detector and camera clock
// indication arrive asynchronously on pins; the camera clock indication
// must toggle slower than a quarter of ref_clk (a divided copy).
`timescale 1ns/1ps
`include "camera_safe_power_regs.vh"

module camera_safe_power_sequencer #(
    parameter CNT_W      = 24,
    parameter BOOT_CYC   = `BOOT_DELAY_CYC,
    parameter LOSS_CYC   = `CLK_LOSS_CYC,
    parameter WAIT_CYC   = `CLK_WAIT_CYC
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        cam_clk_in,
    input  wire        sense_valid_in,
    input  wire        sense_capable_in,
    input  wire        overcurrent_in,
    output reg         test_voltage_en,
    output reg         power_switch_en,
    output reg         lines_ground_en,
    output wire        irq
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_SENSE = 3'h1;
    localparam [2:0] S_BOOT  = 3'h2;
    localparam [2:0] S_WAIT  = 3'h3;
    localparam [2:0] S_RUN   = 3'h4;

    localparam [CNT_W-1:0] BOOT_LOAD = BOOT_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] LOSS_LOAD = LOSS_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] WAIT_LOAD = WAIT_CYC[CNT_W-1:0];

    // Counts down to zero and stays there.
    function [CNT_W-1:0] dec_sat;
        input [CNT_W-1:0] v;
        begin
            dec_sat = (v == {CNT_W{1'b0}}) ? v : v - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Pin synchronisers: bit 0 camera clock, 1 sense valid, 2 capable,
    // 3 overcurrent. A new level is accepted once stages two and three agree.
    reg  [3:0] sync1_q;
    reg  [3:0] sync2_q;
    reg  [3:0] sync3_q;
    reg  [3:0] filt_q;
    wire [3:0] filt_d;

    assign filt_d = (~(sync2_q ^ sync3_q) & sync3_q) |
                    ((sync2_q ^ sync3_q) & filt_q);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            filt_q  <= 4'h0;
        end else begin
            sync1_q <= {overcurrent_in, sense_capable_in,
                        sense_valid_in, cam_clk_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    wire cam_lvl    = filt_q[0];
    wire sense_ok   = filt_q[1];
    wire capable    = filt_q[2];
    wire overcur    = filt_q[3];

    // Clock presence: any edge reloads the loss window.
    reg              cam_last_q;
    reg  [CNT_W-1:0] loss_cnt_q;
    wire             cam_edge   = cam_lvl ^ cam_last_q;
    wire             clk_present = (loss_cnt_q != {CNT_W{1'b0}});

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cam_last_q <= 1'b0;
            loss_cnt_q <= {CNT_W{1'b0}};
        end else begin
            cam_last_q <= cam_lvl;
            if (cam_edge) begin
                loss_cnt_q <= LOSS_LOAD;
            end else begin
                loss_cnt_q <= dec_sat(loss_cnt_q);
            end
        end
    end

    // Avalon-MM slave: every access waits exactly one cycle.
    reg         ack_q;
    wire        req      = avs_read | avs_write;
    wire        wr_done  = avs_write & ack_q;
    wire        rd_done  = avs_read & ack_q;

    assign avs_waitrequest = req & ~ack_q;

    reg         enable_q;
    reg         enable_d;
    reg  [3:0]  irq_stat_q;
    reg  [3:0]  irq_mask_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [CNT_W-1:0] tmr_q;
    reg  [CNT_W-1:0] tmr_d;
    reg  [3:0]  events;

    wire sw_en_wr = wr_done & (avs_address == `REG_CONTROL) &
                    avs_byteenable[0];

    always @* begin
        state_d  = state_q;
        tmr_d    = dec_sat(tmr_q);
        enable_d = enable_q;
        events   = 4'h0;
        if (sw_en_wr) begin
            enable_d = avs_writedata[`CTRL_ENABLE_BIT];
        end
        case (state_q)
            S_IDLE: begin
                if (enable_q) begin
                    state_d = S_SENSE;
                end
            end
            S_SENSE: begin
                // A non-capable result simply keeps sensing, unpowered.
                if (sense_ok && capable) begin
                    state_d = S_BOOT;
                    tmr_d   = BOOT_LOAD;
                    events[`IRQ_FOUND_BIT] = 1'b1;
                end
            end
            S_BOOT: begin
                if (tmr_q == {CNT_W{1'b0}}) begin
                    state_d = S_WAIT;
                    tmr_d   = WAIT_LOAD;
                end
            end
            S_WAIT: begin
                if (clk_present) begin
                    state_d = S_RUN;
                    events[`IRQ_RUN_BIT] = 1'b1;
                end else if (tmr_q == {CNT_W{1'b0}}) begin
                    state_d = S_SENSE;
                    events[`IRQ_LOST_BIT] = 1'b1;
                end
            end
            S_RUN: begin
                if (!clk_present) begin
                    state_d = S_SENSE;
                    events[`IRQ_LOST_BIT] = 1'b1;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        // Outside S_IDLE, overcurrent outranks a same-cycle software write of the enable,
        // so a fault can never be masked by a racing restart.
        if (overcur && state_q != S_IDLE) begin
            state_d  = S_IDLE;
            enable_d = 1'b0;
            events[`IRQ_OVERCUR_BIT] = 1'b1;
        end else if (!enable_q) begin
            state_d = S_IDLE;
        end
    end

    wire powered_d = (state_d == S_BOOT) | (state_d == S_WAIT) |
                     (state_d == S_RUN);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q         <= S_IDLE;
            tmr_q           <= {CNT_W{1'b0}};
            enable_q        <= `CTRL_RESET;
            power_switch_en <= 1'b0;
            lines_ground_en <= 1'b1;
            test_voltage_en <= 1'b0;
        end else begin
            state_q         <= state_d;
            tmr_q           <= tmr_d;
            enable_q        <= enable_d;
            power_switch_en <= powered_d;
            lines_ground_en <= (state_d == S_IDLE);
            test_voltage_en <= (state_d == S_SENSE);
        end
    end

    // Read-only state reflection.
    wire [5:0] flags;
    assign flags[`ST_POWER_BIT]   = power_switch_en;
    assign flags[`ST_GROUND_BIT]  = lines_ground_en;
    assign flags[`ST_AWAIT_BIT]   = (state_q == S_WAIT);
    assign flags[`ST_SENSE_BIT]   = (state_q == S_SENSE);
    assign flags[`ST_CLKSEEN_BIT] = (state_q == S_RUN);
    assign flags[`ST_FOUND_BIT]   = (state_q == S_BOOT) |
                                    (state_q == S_WAIT) |
                                    (state_q == S_RUN);

    // Sticky interrupt status; a new event wins over the read that clears.
    // Only the bits captured into the read data are cleared, so an event
    // landing between capture and completion is not lost.
    wire       stat_rd  = rd_done & (avs_address == `REG_IRQ_STATUS);
    wire [3:0] stat_clr = stat_rd ? avs_readdata[3:0] : 4'h0;

    assign irq = |(irq_stat_q & irq_mask_q);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0;
            irq_stat_q   <= `IRQ_RESET;
            irq_mask_q   <= `IRQ_RESET;
        end else begin
            ack_q      <= req & ~ack_q;
            irq_stat_q <= (irq_stat_q & ~stat_clr) | events;
            if (wr_done && avs_address == `REG_IRQ_MASK &&
                avs_byteenable[0]) begin
                irq_mask_q <= avs_writedata[3:0];
            end
            if (avs_read && !ack_q) begin
                case (avs_address)
                    `REG_CONTROL:    avs_readdata <= {31'h0, enable_q};
                    `REG_STATUS:     avs_readdata <= {26'h0, flags};
                    `REG_IRQ_STATUS: avs_readdata <= {28'h0, irq_stat_q};
                    `REG_IRQ_MASK:   avs_readdata <= {28'h0, irq_mask_q};
                    default:         avs_readdata <= 32'h0;
                endcase
            end
        end
    end

endmodule

// *** core/camera_safe_power_regs.vh ***
// Constants for the camera safe-power sequencer: offsets, fields, resets
// and timing. Assumes a 200 MHz reference clock and byte addressing.
`ifndef CAMERA_SAFE_POWER_REGS_VH
`define CAMERA_SAFE_POWER_REGS_VH

`define REG_CONTROL      4'h0
`define REG_STATUS       4'h4
`define REG_IRQ_STATUS   4'h8
`define REG_IRQ_MASK     4'hC

`define CTRL_ENABLE_BIT  0
`define CTRL_RESET       1'b0

`define ST_POWER_BIT     0
`define ST_GROUND_BIT    1
`define ST_AWAIT_BIT     2
`define ST_SENSE_BIT     3
`define ST_CLKSEEN_BIT   4
`define ST_FOUND_BIT     5

`define IRQ_FOUND_BIT    0
`define IRQ_RUN_BIT      1
`define IRQ_LOST_BIT     2
`define IRQ_OVERCUR_BIT  3
`define IRQ_RESET        4'h0

`define REF_CLK_MHZ      200
`define BOOT_DELAY_US    100
`define BOOT_DELAY_CYC   (`BOOT_DELAY_US * `REF_CLK_MHZ)
`define CLK_LOSS_US      10
`define CLK_LOSS_CYC     (`CLK_LOSS_US * `REF_CLK_MHZ)
`define CLK_WAIT_US      1000
`define CLK_WAIT_CYC     (`CLK_WAIT_US * `REF_CLK_MHZ)

`endif

// *** tb/camera_safe_power_chk.sv ***
// Port checker for the camera safe-power sequencer.
// Assumes it is bound onto the sequencer; one clock, ref_clk.
`timescale 1ns/1ps
module camera_safe_power_chk (
    input logic ref_clk,
    input logic rst_n,
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    input logic sense_valid_in,
    input logic sense_capable_in,
    input logic overcurrent_in,
    input logic test_voltage_en,
    input logic power_switch_en,
    input logic lines_ground_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ground_only_a: assert property (
        lines_ground_en |-> !power_switch_en && !test_voltage_en)
        else $error("grounded while driven");
    sense_off_a: assert property (
        test_voltage_en |-> !power_switch_en) else $error("power in sense");
    leave_idle_a: assert property (
        $fell(lines_ground_en) |-> test_voltage_en) else $error("idle exit");
    drop_power_a: assert property (
        $fell(power_switch_en) |-> test_voltage_en || lines_ground_en)
        else $error("power drop target");
    power_cause_a: assert property (
        $rose(power_switch_en) |->
            $past(sense_valid_in && sense_capable_in, 2))
        else $error("power without capable camera");
    overcur_off_a: assert property (
        overcurrent_in [*6] |-> !power_switch_en) else $error("overcurrent");
    wait_first_a: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait");
    wait_once_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
endmodule
bind camera_safe_power_sequencer camera_safe_power_chk i_chk (.*);

// *** tb/camera_partner.sv ***
// Camera on the cable: answers the impedance test and returns a clock.
// Assumes cap and clk_run are steered by the bench.
`timescale 1ns/1ps
module camera_partner (
    input  wire ref_clk,
    input  wire test_voltage_en,
    input  wire power_switch_en,
    input  wire cap,
    input  wire clk_run,
    output reg  sense_valid_in = 1'b0,
    output reg  sense_capable_in = 1'b0,
    output reg  cam_clk_in = 1'b0
);
    reg [1:0] mode_q = 2'h0;
    reg [7:0] t_q = 8'h00;
    reg [1:0] div_q = 2'h0;
    always @(posedge ref_clk) begin
        mode_q <= {power_switch_en, test_voltage_en};
        div_q <= div_q + 2'h1;
        t_q <= (mode_q != {power_switch_en, test_voltage_en}) ? 8'h00 :
               (t_q == 8'hFF) ? t_q : t_q + 8'h01;
        // The answer settles late so that the sensing state is visible.
        sense_valid_in <= test_voltage_en && t_q > 8'h10;
        sense_capable_in <= test_voltage_en ? cap && t_q > 8'h10 :
                            ~sense_capable_in;
        // The clock stands still unless the camera is powered and booted.
        if (power_switch_en && clk_run && t_q > 8'h28 && div_q == 2'h3) begin
            cam_clk_in <= ~cam_clk_in;
        end
    end
endmodule

// *** tb/camera_safe_power_sequencer_bench.sv ***
// Self-checking bench for the camera safe-power sequencer.
// Assumes core/ on the include path and the camera model on the pins.
`timescale 1ns/1ps
`include "camera_safe_power_regs.vh"
module camera_safe_power_sequencer_bench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        overcurrent_in = 1'b0;
    logic        cap = 1'b1;
    logic        clk_run = 1'b1;
    logic [31:0] avs_readdata, q, d;
    logic [3:0]  b;
    logic        avs_waitrequest, cam_clk_in, sense_valid_in, en;
    logic        sense_capable_in, test_voltage_en, power_switch_en;
    logic        lines_ground_en, irq;
    int          n_errors = 0;
    int          checks_done = 0;
    int          seed = 25;
    camera_safe_power_sequencer #(.BOOT_CYC(20), .LOSS_CYC(16), .WAIT_CYC(60))
        i_camera_safe_power_sequencer (.*);
    camera_partner i_camera_partner (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    function logic exp_en(logic [3:0] be, logic [31:0] wd, logic p);
        return be[0] ? wd[0] : p;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp, string w);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        // Waitrequest is read in the edge's own step, before the registers
        // update, so it is the value the slave showed at that edge.
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n == 50) begin
                n_errors++;
                complete_run;
            end
            @(posedge ref_clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task pins(input logic [3:0] e, string w);
        @(negedge ref_clk);
        chk({28'h0, irq, power_switch_en, test_voltage_en, lines_ground_en},
            {28'h0, e}, w);
        @(posedge ref_clk);
    endtask
    // Waits on power (0) or test voltage (1) so the bench never hangs.
    task wt(input int w);
        int n;
        n = 0;
        while ((w ? test_voltage_en : power_switch_en) !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 400) begin
            n_errors++;
            complete_run;
        end
        @(posedge ref_clk);
    endtask
    task poll(input logic [31:0] from);
        int n;
        n = 0;
        do begin
            bus(0, `REG_STATUS, 0);
            n++;
        end while (q === from && n < 100);
        if (n == 100) begin
            n_errors++;
            complete_run;
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(5 * 20000);
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        pins(4'h1, "reset pins");
        bus(0, `REG_CONTROL, 0);
        chk(q, 32'h0, "enable reset");
        bus(1, `REG_STATUS, 32'hFFFFFFFF);
        bus(0, `REG_STATUS, 0);
        chk(q, 32'h2, "status");
        bus(1, `REG_IRQ_MASK, 32'hF);
        bus(1, `REG_CONTROL, 1);
        wt(1);
        bus(0, `REG_STATUS, 0);
        chk(q, 32'h8, "sensing");
        wt(0);
        bus(0, `REG_STATUS, 0);
        chk(q, 32'h21, "found");
        poll(32'h21);
        chk(q, 32'h25, "awaiting");
        poll(32'h25);
        chk(q, 32'h31, "running");
        pins(4'hC, "run irq");
        bus(0, `REG_IRQ_STATUS, 0);
        chk(q, 32'h3, "events");
        pins(4'h4, "irq cleared");
        $display("test power up done");
        cap <= 1'b0;
        clk_run <= 1'b0;
        wt(1);
        pins(4'hA, "clock lost");
        bus(1, `REG_IRQ_MASK, 0);
        bus(0, `REG_IRQ_STATUS, 0);
        chk(q, 32'h4, "lost event");
        repeat (40) @(posedge ref_clk);
        pins(4'h2, "incapable");
        cap <= 1'b1;
        wt(0);
        wt(1);
        bus(0, `REG_IRQ_STATUS, 0);
        chk(q, 32'h5, "wait timeout");
        pins(4'h2, "timeout unpowered");
        $display("test loss done");
        cap <= 1'b1;
        clk_run <= 1'b1;
        wt(0);
        repeat (60) @(posedge ref_clk);
        bus(0, `REG_IRQ_STATUS, 0);
        overcurrent_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        overcurrent_in <= 1'b0;
        bus(0, `REG_CONTROL, 0);
        chk(q, 32'h0, "enable cleared");
        bus(0, `REG_IRQ_STATUS, 0);
        chk(q & 32'h8, 32'h8, "overcurrent event");
        repeat (40) @(posedge ref_clk);
        pins(4'h1, "stays off");
        bus(1, `REG_CONTROL, 1);
        wt(1);
        pins(4'h2, "restart");
        bus(1, `REG_CONTROL, 0);
        pins(4'h1, "disabled");
        $display("test overcurrent done");
        en = 1'b0;
        repeat (6) begin
            b = $random(seed);
            d = $random(seed);
            avs_byteenable <= b;
            bus(1, `REG_CONTROL, d);
            en = exp_en(b, d, en);
            avs_byteenable <= 4'hF;
            bus(0, `REG_CONTROL, 0);
            chk(q, {31'h0, en}, "enable rw");
        end
        bus(1, `REG_CONTROL, 0);
        bus(0, 4'h2, 0);
        chk(q, 32'h0, "unmapped");
        $display("test random done");
        complete_run;
    end
endmodule
